// File: verilog/radio_modem_config_bank.sv
// Configuration register bank of a sub-GHz radio, reached over AHB-Lite.
// Assumes one clock, a single AHB-Lite master, and a FIFO level from the radio core
// that arrives from outside the clock domain.
//
// Our own choice: the AHB-Lite interface to the registers.
`include "radio_cfg_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module radio_modem_config_bank (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [6:0] FIFO_FILL,
   output radio_cfg_pkg::radio_settings_t SETTINGS,
   output logic IRQ
);
   // Stored registers.
   logic [7:0] general_config_reg;
   logic [7:0] data_modulation_config_reg;
   logic [7:0] frequency_deviation_reg;
   logic [7:0] bit_rate_set_reg;
   logic [7:0] ook_floor_threshold_reg;
   logic [7:0] fifo_config_reg;
   logic [7:0] first_ref_divider_reg;
   logic [2:0] irq_status_reg;
   logic [2:0] irq_mask_reg;
   // Second dividers stand outside this bank; the second set reads as a plain default.
   logic [7:0] second_ref_divider;
   // Latched address phase.
   logic wr_pend_reg;
   logic [7:0] addr_reg;
   // Synchroniser of the FIFO level.
   logic [6:0] fill_meta_reg;
   logic [6:0] fill_sync_reg;
   // Previous synchronised sample, and the last level seen twice in a row.
   logic [6:0] fill_seen_reg;
   logic [6:0] fill_stable_reg;
   // Decoded settings, combinational and registered.
   radio_cfg_pkg::radio_settings_t settings_next;
   logic fifo_event;
   logic [2:0] irq_events;
   logic [2:0] irq_clear;
   logic [31:0] rdata_next;
   logic addr_phase;

   assign second_ref_divider = 8'h74;

   // Decodes a byte address into the register index.
   function automatic logic [7:0] word_index(input logic [31:0] a);
      word_index = {2'b00, a[7:2]};
   endfunction : word_index

   // Maps the depth select code to a byte count.
   function automatic logic [6:0] depth_bytes(input logic [1:0] code);
      case (code)
         2'b00: depth_bytes = 7'h10; // see (R10)
         2'b01: depth_bytes = 7'h20; // see (R10)
         2'b10: depth_bytes = 7'h30; // see (R10)
         default: depth_bytes = 7'h40; // see (R10)
      endcase
   endfunction : depth_bytes

   // Maps the chip mode field to its one-hot state.
   function automatic radio_cfg_pkg::chip_mode_t chip_decode(input logic [2:0] code);
      case (code)
         3'b000: chip_decode = radio_cfg_pkg::CHIP_SLEEP; // see (R15)
         3'b001: chip_decode = radio_cfg_pkg::CHIP_STANDBY; // see (R15)
         3'b010: chip_decode = radio_cfg_pkg::CHIP_SYNTH; // see (R15)
         3'b011: chip_decode = radio_cfg_pkg::CHIP_RECEIVE; // see (R15)
         3'b100: chip_decode = radio_cfg_pkg::CHIP_TRANSMIT; // see (R15)
         default: chip_decode = radio_cfg_pkg::CHIP_RESERVED;
      endcase
   endfunction : chip_decode

   // A valid address phase is one selected, NONSEQ or SEQ (HTRANS[1] set), with the bus ready.
   assign addr_phase = HSEL & HTRANS[1] & HREADY;

   // Latches the address phase; writes land in the following data phase.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= addr_phase & HWRITE;
         if (addr_phase) begin
            addr_reg <= word_index(HADDR);
         end
      end
   end

   // Writes the configuration registers in the data phase; the new value steers
   // the radio from the second edge on, through the registered settings.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         general_config_reg <= `RST_GENERAL;
         data_modulation_config_reg <= `RST_DMOD;
         frequency_deviation_reg <= `RST_FDEV;
         bit_rate_set_reg <= `RST_RATE;
         ook_floor_threshold_reg <= `RST_FLOOR;
         fifo_config_reg <= `RST_FIFO;
         first_ref_divider_reg <= `RST_RDIV;
         irq_mask_reg <= 3'h0;
      end else if (wr_pend_reg) begin
         case (addr_reg)
            `IDX_GENERAL: general_config_reg <= HWDATA[7:0]; // see (R16)
            `IDX_DMOD: data_modulation_config_reg <= HWDATA[7:0]; // see (R16)
            `IDX_FDEV: frequency_deviation_reg <= HWDATA[7:0]; // see (R5)
            // Reserved bit is forced to zero so it never carries a function.
            `IDX_RATE: bit_rate_set_reg <= {1'b0, HWDATA[6:0]}; // see (R7)
            `IDX_FLOOR: ook_floor_threshold_reg <= HWDATA[7:0]; // see (R9)
            `IDX_FIFO: fifo_config_reg <= HWDATA[7:0]; // see (R11)
            `IDX_RDIV: first_ref_divider_reg <= HWDATA[7:0]; // see (R13)
            `IDX_IRQ_MASK: irq_mask_reg <= HWDATA[2:0];
            default: begin
            end
         endcase
      end
   end

   // Two flip-flops bring the FIFO level into the clock domain.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fill_meta_reg <= 7'h00;
         fill_sync_reg <= 7'h00;
      end else begin
         fill_meta_reg <= FIFO_FILL;
         fill_sync_reg <= fill_meta_reg;
      end
   end

   // A multi-bit level can be caught mid-change; a value is taken only once two
   // successive synchronised samples agree, so a torn word never reaches the detector.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         fill_seen_reg <= 7'h00;
         fill_stable_reg <= 7'h00;
      end else begin
         fill_seen_reg <= fill_sync_reg;
         if (fill_sync_reg == fill_seen_reg) begin
            fill_stable_reg <= fill_sync_reg;
         end
      end
   end

   // Decodes the stored fields into the settings carried to the radio.
   always_comb begin
      settings_next = '0;
      // Reserved codes pass through as reserved; the radio treats them as no change.
      case (data_modulation_config_reg[7:6])
         2'b10: settings_next.modulation = radio_cfg_pkg::MOD_FSK; // see (R1)
         2'b01: settings_next.modulation = radio_cfg_pkg::MOD_OOK; // see (R1)
         default: settings_next.modulation = radio_cfg_pkg::MOD_RESERVED;
      endcase
      // High data-mode bit at 2 wins; low bit at 5 then picks buffered.
      if (data_modulation_config_reg[2]) begin
         settings_next.data_mode = radio_cfg_pkg::DATA_PACKET; // see (R2)
      end else if (data_modulation_config_reg[5]) begin
         settings_next.data_mode = radio_cfg_pkg::DATA_BUFFERED; // see (R2)
      end else begin
         settings_next.data_mode = radio_cfg_pkg::DATA_CONTINUOUS; // see (R2)
      end
      settings_next.ook_threshold_type = data_modulation_config_reg[4:3]; // see (R3)
      settings_next.if_attenuation = data_modulation_config_reg[1:0]; // see (R4)
      settings_next.deviation_value = frequency_deviation_reg; // see (R5)
      settings_next.rate_value = bit_rate_set_reg[6:0]; // see (R6)
      settings_next.ook_floor_value = ook_floor_threshold_reg; // see (R9)
      settings_next.fifo_depth_bytes = depth_bytes(fifo_config_reg[7:6]); // see (R10)
      settings_next.fifo_level_trigger = fifo_config_reg[5:0]; // see (R11)
      settings_next.divider_set_select = general_config_reg[`GEN_SET_SEL_BIT]; // see (R14)
      // The first divider reaches the synthesiser only while the first set is chosen.
      if (general_config_reg[`GEN_SET_SEL_BIT]) begin
         settings_next.active_ref_divider = second_ref_divider; // see (R14)
      end else begin
         settings_next.active_ref_divider = first_ref_divider_reg; // see (R13)
      end
      settings_next.chip_mode = chip_decode(general_config_reg[7:5]); // see (R15)
   end

   // Registers the settings so every output comes from a flip-flop.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         SETTINGS <= '0;
      end else begin
         SETTINGS <= settings_next;
      end
   end

   // Detects the mode-dependent FIFO threshold event.
   fifo_thresh_detect u_thresh (
      .clk(CLK),
      .rst(RST),
      .chip_mode(SETTINGS.chip_mode),
      .fill_level(fill_stable_reg),
      .fifo_level_trigger(SETTINGS.fifo_level_trigger),
      .fifo_depth_bytes(SETTINGS.fifo_depth_bytes),
      .event_pulse(fifo_event)
   );

   // Events: FIFO threshold, chip mode change, and a write that set the reserved rate bit.
   assign irq_events[`IRQ_FIFO_THRESH] = fifo_event; // see (R12)
   // Mode change is taken from the write itself, so leaving reset raises no false event.
   assign irq_events[`IRQ_MODE_CHANGE] = wr_pend_reg & (addr_reg == `IDX_GENERAL)
      & (HWDATA[7:5] != general_config_reg[7:5]);
   assign irq_events[`IRQ_RATE_RSVD] = wr_pend_reg & (addr_reg == `IDX_RATE)
      & HWDATA[`RATE_RSVD_BIT]; // see (R7)
   assign irq_clear = (wr_pend_reg && addr_reg == `IDX_IRQ_STATUS) ? HWDATA[2:0] : 3'h0;

   // Sticky status bits; an event in the clearing cycle wins over the clear.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         irq_status_reg <= 3'h0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      end
   end

   // Level interrupt while any unmasked status bit is set.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(((irq_status_reg & ~irq_clear) | irq_events) & irq_mask_reg);
      end
   end

   // Selects read data from the address of the current address phase.
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (word_index(HADDR))
         `IDX_GENERAL: rdata_next[7:0] = general_config_reg; // see (R16)
         `IDX_DMOD: rdata_next[7:0] = data_modulation_config_reg; // see (R16)
         `IDX_FDEV: rdata_next[7:0] = frequency_deviation_reg; // see (R16)
         `IDX_RATE: rdata_next[7:0] = bit_rate_set_reg; // see (R16)
         `IDX_FLOOR: rdata_next[7:0] = ook_floor_threshold_reg; // see (R16)
         `IDX_FIFO: rdata_next[7:0] = fifo_config_reg; // see (R16)
         `IDX_RDIV: rdata_next[7:0] = first_ref_divider_reg; // see (R16)
         `IDX_IRQ_STATUS: rdata_next[2:0] = irq_status_reg;
         `IDX_IRQ_MASK: rdata_next[2:0] = irq_mask_reg;
         `IDX_FIFO_LEVEL: rdata_next[6:0] = fill_stable_reg;
         `IDX_DERIVED: rdata_next[7:0] = SETTINGS.active_ref_divider;
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data is captured at the end of the address phase and stands in the data phase.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         HRDATA <= 32'h0000_0000;
      end else if (addr_phase & ~HWRITE) begin
         HRDATA <= rdata_next;
      end
   end

   // Zero wait states and OKAY for every transfer, unmapped ones read zero.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end
endmodule : radio_modem_config_bank
`default_nettype wire

// File: verilog/radio_cfg_consts.svh
// Offsets, reset values, field positions and rate constants of the radio configuration bank.
// Assumes inclusion by bare name from the bank module, the host model and the bench.
//
// Contract
// (R1) Modulation select: 10 FSK default, 01 OOK.
// (R2) Data mode: 00 continuous, 01 buffered, 1x packet.
// (R3) OOK threshold: 00 fixed, 01 peak, 10 average.
// (R4) IF attenuation codes: 0, -4.5, -9, -13.5 dB.
// (R5) Deviation is xtal over 32 times value+1.
// (R6) Bit rate is xtal over 64 times value+1.
// (R7) Host keeps bit-rate bit 7 at zero.
// (R8) Rate figures assume a 12.8 MHz crystal.
// (R9) Floor threshold counts 0.5 dB RSSI steps.
// (R10) FIFO depth codes: 16, 32, 48, 64 bytes.
// (R11) FIFO threshold level field, default 001111.
// (R12) FIFO threshold event depends on chip mode.
// (R13) First divider used only while set select is 0.
// (R14) Set select: 0 first set, 1 second set.
// (R15) Chip mode: sleep, standby, synth, receive, transmit.
// (R16) Reads return last written value or default; the rate register returns bit 7 as zero even after a write that set it.
`ifndef RADIO_CFG_CONSTS_SVH
`define RADIO_CFG_CONSTS_SVH

// Register indices; the byte address on the bus is the index times four.
`define IDX_GENERAL 8'h00
`define IDX_DMOD 8'h01
`define IDX_FDEV 8'h02
`define IDX_RATE 8'h03
`define IDX_FLOOR 8'h04
`define IDX_FIFO 8'h05
`define IDX_RDIV 8'h06
`define IDX_IRQ_STATUS 8'h20
`define IDX_IRQ_MASK 8'h21
`define IDX_FIFO_LEVEL 8'h22
`define IDX_DERIVED 8'h23

// Power-on values.
`define RST_GENERAL 8'h28
`define RST_DMOD 8'h88
`define RST_FDEV 8'h03
`define RST_RATE 8'h07
`define RST_FLOOR 8'h0C
`define RST_FIFO 8'h0F
`define RST_RDIV 8'h77

// Field positions.
`define RATE_RSVD_BIT 7
`define GEN_SET_SEL_BIT 0

// Crystal reference in kHz and the scale factors of the rate formulas.
`define XTAL_KHZ 12800 // see (R8)
`define DEV_SCALE 32
`define RATE_SCALE 64

// Interrupt status bit positions.
`define IRQ_FIFO_THRESH 0
`define IRQ_MODE_CHANGE 1
`define IRQ_RATE_RSVD 2

`endif

// File: verilog/radio_cfg_pkg.sv
// Types shared by the radio configuration bank.
// Assumes the constants header is on the include path.
package radio_cfg_pkg;

   // Decoded modulation kind.
   typedef enum logic [1:0] {MOD_RESERVED = 2'b00, MOD_OOK = 2'b01, MOD_FSK = 2'b10} modulation_t;

   // Decoded data operation mode.
   typedef enum logic [1:0] {DATA_CONTINUOUS = 2'b00, DATA_BUFFERED = 2'b01,
      DATA_PACKET = 2'b10} data_mode_t;

   // Decoded chip mode, one-hot.
   typedef enum logic [5:0] {
      CHIP_SLEEP = 6'b00_0001,
      CHIP_STANDBY = 6'b00_0010,
      CHIP_SYNTH = 6'b00_0100,
      CHIP_RECEIVE = 6'b00_1000,
      CHIP_TRANSMIT = 6'b01_0000,
      CHIP_RESERVED = 6'b10_0000
   } chip_mode_t;

   // Settings handed to the radio paths.
   typedef struct packed {
      modulation_t modulation;
      data_mode_t data_mode;
      logic [1:0] ook_threshold_type;
      logic [1:0] if_attenuation;
      logic [7:0] deviation_value;
      logic [6:0] rate_value;
      logic [7:0] ook_floor_value;
      logic [6:0] fifo_depth_bytes;
      logic [5:0] fifo_level_trigger;
      logic [7:0] active_ref_divider;
      logic divider_set_select;
      chip_mode_t chip_mode;
   } radio_settings_t;

endpackage : radio_cfg_pkg

// File: verilog/fifo_thresh_detect.sv
// FIFO threshold event detector for the radio configuration bank.
// Assumes the FIFO fill level arrives synchronised on the same clock.
`timescale 1ns/1ns
`default_nettype none
module fifo_thresh_detect (
   input wire logic clk,
   input wire logic rst,
   input wire radio_cfg_pkg::chip_mode_t chip_mode,
   input wire logic [6:0] fill_level,
   input wire logic [5:0] fifo_level_trigger,
   input wire logic [6:0] fifo_depth_bytes,
   output logic event_pulse
);
   // Threshold condition of the present cycle and its previous value.
   logic cond;
   logic cond_reg;

   // The condition's sense depends on mode: transmit watches the FIFO draining to the
   // trigger, receive watches it filling past it, standby watches a full FIFO.
   always_comb begin
      case (chip_mode)
         radio_cfg_pkg::CHIP_TRANSMIT: begin
            cond = (fill_level <= {1'b0, fifo_level_trigger}); // see (R12)
         end
         radio_cfg_pkg::CHIP_RECEIVE: begin
            cond = (fill_level > {1'b0, fifo_level_trigger}); // see (R12)
         end
         radio_cfg_pkg::CHIP_STANDBY: begin
            cond = (fill_level >= fifo_depth_bytes); // see (R12)
         end
         default: begin
            cond = 1'b0;
         end
      endcase
   end

   // Remembers the condition so that only its rising edge makes an event.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cond_reg <= 1'b0;
      end else begin
         cond_reg <= cond;
      end
   end

   // One-cycle pulse on the rising edge of the condition.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         event_pulse <= 1'b0;
      end else begin
         event_pulse <= cond & ~cond_reg;
      end
   end
endmodule : fifo_thresh_detect
`default_nettype wire

// File: verification/radio_cfg_assertions.sv
// Concurrent checks on the radio bank's bus and settings ports.
// Assumes zero wait states and settings that follow a write two edges on.
`timescale 1ns/1ns
`default_nettype none
module radio_cfg_assertions (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [6:0] FIFO_FILL,
   input wire radio_cfg_pkg::radio_settings_t SETTINGS,
   input wire logic IRQ
);
   logic dph_wr; // A write is in its data phase.
   logic [5:0] dph_idx; // Register index of that write.
   // Follows each accepted write into its data phase.
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         dph_wr <= 1'b0;
         dph_idx <= 6'h00;
      end else begin
         dph_wr <= HSEL & HTRANS[1] & HREADY & HWRITE;
         dph_idx <= HADDR[7:2];
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // Data phases of writes to the modulation and FIFO registers.
   sequence s_dmod_wr;
      dph_wr && dph_idx == 6'h01;
   endsequence
   sequence s_fifo_wr;
      dph_wr && dph_idx == 6'h05;
   endsequence
   a_bus_okay: assert property (!HRESP && HREADYOUT)
      else $error("Bus answer not OKAY with zero waits.");
   a_mod_select: assert property (s_dmod_wr ##0 HWDATA[7] != HWDATA[6] |->
      ##2 SETTINGS.modulation == $past(HWDATA[7:6], 2)) else $error("Modulation wrong.");
   a_data_mode: assert property (s_dmod_wr |-> ##2 SETTINGS.data_mode ==
      ($past(HWDATA[2], 2) ? 2'b10 : {1'b0, $past(HWDATA[5], 2)})) else $error("Data mode.");
   a_ook_type: assert property (s_dmod_wr |->
      ##2 SETTINGS.ook_threshold_type == $past(HWDATA[4:3], 2)) else $error("OOK type.");
   a_if_gain: assert property (s_dmod_wr |->
      ##2 SETTINGS.if_attenuation == $past(HWDATA[1:0], 2)) else $error("IF gain.");
   a_dev_value: assert property (dph_wr && dph_idx == 6'h02 |->
      ##2 SETTINGS.deviation_value == $past(HWDATA[7:0], 2)) else $error("Deviation.");
   a_rate_value: assert property (dph_wr && dph_idx == 6'h03 |->
      ##2 SETTINGS.rate_value == $past(HWDATA[6:0], 2)) else $error("Rate value.");
   a_fifo_depth: assert property (s_fifo_wr |-> ##2 SETTINGS.fifo_depth_bytes ==
      (7'($past(HWDATA[7:6], 2)) + 7'h01) * 7'h10) else $error("FIFO depth.");
   a_fifo_trigger: assert property (s_fifo_wr |->
      ##2 SETTINGS.fifo_level_trigger == $past(HWDATA[5:0], 2)) else $error("Trigger.");
   a_floor_value: assert property (dph_wr && dph_idx == 6'h04 |->
      ##2 SETTINGS.ook_floor_value == $past(HWDATA[7:0], 2)) else $error("Floor value.");
endmodule : radio_cfg_assertions
bind radio_modem_config_bank radio_cfg_assertions u_chk (.CLK(CLK), .RST(RST), .HSEL(HSEL),
   .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
   .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .FIFO_FILL(FIFO_FILL), .SETTINGS(SETTINGS), .IRQ(IRQ));
`default_nettype wire

// File: verification/ahb_host_model.sv
// Host controller model that issues single-word AHB-Lite transfers.
// Assumes one slave whose ready output comes back as HREADY.
`include "radio_cfg_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module ahb_host_model (
   input wire logic CLK,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   output logic HSEL,
   output logic [31:0] HADDR,
   output logic [1:0] HTRANS,
   output logic HWRITE,
   output logic [2:0] HSIZE,
   output logic [31:0] HWDATA
);
   // The bus is idle at time zero.
   initial begin
      HSEL = 1'b0;
      HADDR = 32'h0000_0000;
      HTRANS = 2'h0;
      HWRITE = 1'b0;
      HSIZE = 3'h2;
      HWDATA = 32'h0000_0000;
   end
   // One transfer; the caller enters just after a rising edge.
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
      input logic raw, output logic [31:0] rd);
      logic [7:0] v;
      v = d;
      // The reserved rate bit stays clear unless a refusal is meant.
      if (idx == `IDX_RATE && !raw) begin
         v[`RATE_RSVD_BIT] = 1'b0;
      end
      HSEL <= 1'b1;
      HADDR <= {24'h00_0000, idx[5:0], 2'h0};
      HTRANS <= 2'h2;
      HWRITE <= wr;
      do @(posedge CLK); while (HREADY !== 1'b1);
      HTRANS <= 2'h0;
      HSEL <= 1'b0;
      HWDATA <= {24'h00_0000, v};
      do @(posedge CLK); while (HREADY !== 1'b1);
      rd = HRDATA;
      // A released data line must not keep showing the last value.
      HWDATA <= ~{24'h00_0000, v};
   endtask : xfer
endmodule : ahb_host_model
`default_nettype wire

// File: verification/tb_radio_modem_config_bank.sv
// Self-checking bench for the radio configuration bank.
// Assumes the host model drives the bus and the bench plays the radio core.
`include "radio_cfg_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb_radio_modem_config_bank;
   logic CLK, RST, HSEL, HWRITE, HREADYOUT, HRESP, IRQ;
   logic [31:0] HADDR, HWDATA, HRDATA, rd;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   logic [6:0] FIFO_FILL; // Fill level as the radio core reports it.
   radio_cfg_pkg::radio_settings_t SETTINGS;
   logic [7:0] sh [0:6]; // Expected register contents.
   logic [7:0] d;
   logic [23:0] ft [0:3]; // Mode, fill before, then event flag (bit 7) and fill after.
   integer failures = 0, compares = 0, i;
   ahb_host_model host (.CLK(CLK), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));
   radio_modem_config_bank DUT (.CLK(CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .FIFO_FILL(FIFO_FILL),
      .SETTINGS(SETTINGS), .IRQ(IRQ));
   // The clock runs at 100 MHz.
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   // Decoded settings expected from the shadow registers.
   function automatic radio_cfg_pkg::radio_settings_t exp_set();
      radio_cfg_pkg::radio_settings_t s;
      s.modulation = (sh[1][7] ^ sh[1][6]) ? radio_cfg_pkg::modulation_t'(sh[1][7:6]) :
         radio_cfg_pkg::MOD_RESERVED;
      s.data_mode = radio_cfg_pkg::data_mode_t'(sh[1][2] ? 2'h2 : {1'b0, sh[1][5]});
      s.ook_threshold_type = sh[1][4:3];
      s.if_attenuation = sh[1][1:0];
      s.deviation_value = sh[2];
      s.rate_value = sh[3][6:0];
      s.ook_floor_value = sh[4];
      s.fifo_depth_bytes = 7'h10 * (7'(sh[5][7:6]) + 7'h01);
      s.fifo_level_trigger = sh[5][5:0];
      s.divider_set_select = sh[0][`GEN_SET_SEL_BIT];
      s.active_ref_divider = sh[0][0] ? 8'h74 : sh[6];
      s.chip_mode = radio_cfg_pkg::chip_mode_t'(sh[0][7:5] > 3'h4 ? 6'h20 : 6'h01 << sh[0][7:5]);
      return s;
   endfunction : exp_set
   // Counts a comparison and reports a mismatch.
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Writes a register and keeps the shadow in step.
   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      host.xfer(1'b1, idx, v, 1'b0, rd);
      if (idx < 8'h07) begin
         sh[idx] = (idx == `IDX_RATE) ? {1'b0, v[6:0]} : v;
      end
   endtask : wr
   // Reads a register and compares the whole word.
   task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
      host.xfer(1'b0, idx, 8'h00, 1'b0, rd);
      check(rd, {24'h00_0000, exp});
   endtask : rd_chk
   // Lets the settings catch up, then compares them.
   task automatic set_chk();
      repeat (2) @(posedge CLK);
      check(SETTINGS, exp_set());
   endtask : set_chk
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict
   // Cuts a hang short.
   initial begin
      #300000;
      failures++;
      give_verdict();
   end
   initial begin
      RST = 1'b1;
      FIFO_FILL = 7'h00;
      sh = '{8'h28, 8'h88, 8'h03, 8'h07, 8'h0C, 8'h0F, 8'h77};
      ft = '{24'h60_05_8C, 24'h80_14_8A, 24'h20_03_90, 24'h00_02_28};
      void'($urandom(30339));
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      for (i = 0; i < 7; i++) rd_chk(i, sh[i]);
      set_chk();
      // Default deviation, rate and floor give the documented figures.
      check(`XTAL_KHZ / (`DEV_SCALE * (SETTINGS.deviation_value + 1)), 100);
      check(`XTAL_KHZ / (`RATE_SCALE * (SETTINGS.rate_value + 1)), 25);
      check(SETTINGS.ook_floor_value / 2, 6);
      rd_chk(`IDX_IRQ_MASK, 8'h00);
      wr(8'h10, 8'hA5); // Unmapped places read zero.
      rd_chk(8'h10, 8'h00);
      host.xfer(1'b1, `IDX_RATE, 8'hFF, 1'b1, rd);
      sh[3] = 8'h7F;
      rd_chk(`IDX_RATE, 8'h7F);
      rd_chk(`IDX_IRQ_STATUS, 8'h04);
      wr(`IDX_IRQ_STATUS, 8'h07);
      rd_chk(`IDX_IRQ_STATUS, 8'h00);
      wr(`IDX_GENERAL, 8'h60); // Standby to receive raises the mode change bit.
      rd_chk(`IDX_IRQ_STATUS, 8'h02);
      // Every code of each general, modulation and FIFO field except the reserved modulation codes
      // and most trigger levels (only 63 down to 56), with the divider set toggling.
      for (i = 0; i < 8; i++) begin
         d = {i[2:0], 4'h4, i[0]};
         wr(`IDX_GENERAL, d);
         wr(`IDX_DMOD, {~i[0], i[0], i[1], i[1:0], i[0], i[1:0]});
         wr(`IDX_FIFO, {i[1:0], 6'h3F - i[5:0]});
         set_chk();
      end
      // Random traffic, partly back to back; some modulation codes left reserved.
      for (i = 0; i < 30; i++) begin
         d = $urandom;
         if (i % 14 == 1) d[7:6] = d[0] ? 2'h1 : 2'h2;
         wr(i % 7, d);
         if ($urandom % 2) set_chk();
      end
      for (i = 0; i < 7; i++) rd_chk(i, sh[i]);
      set_chk();
      // FIFO threshold events in receive, transmit, standby and sleep, transmit and standby at their boundaries.
      wr(`IDX_IRQ_MASK, 8'h01);
      for (i = 0; i < 4; i++) begin
         wr(`IDX_FIFO, 8'h0A);
         wr(`IDX_GENERAL, ft[i][23:16]);
         FIFO_FILL <= ft[i][14:8];
         repeat (8) @(posedge CLK);
         wr(`IDX_IRQ_STATUS, 8'h07);
         repeat (3) @(posedge CLK);
         check(IRQ, 1'b0);
         FIFO_FILL <= ft[i][6:0];
         repeat (8) @(posedge CLK);
         check(IRQ, ft[i][7]);
         rd_chk(`IDX_IRQ_STATUS, {7'h00, ft[i][7]});
         rd_chk(`IDX_FIFO_LEVEL, {1'b0, ft[i][6:0]});
      end
      wr(`IDX_IRQ_MASK, 8'h00);
      repeat (3) @(posedge CLK);
      check(IRQ, 1'b0);
      give_verdict();
   end
endmodule : tb_radio_modem_config_bank
`default_nettype wire
